/* File: rtcpw_pkg.sv */
// Functional notes
// - No off-chip pins; internal connections only
// - Bit 7 flag sets on modulo match
// - Write 1 clears flag; 0 ignored; reset clears
// - Bits 6:5 pick low-power, external, internal source
// - Bit 4 gates flag onto interrupt request
// - Bits 3:0 with source bit 0; zero stops
// - Source bit 0 clear: listed binary/decimal ratios
// - Source bit 0 set: listed larger ratios
// - Changed source or prescale clears both counters
// - Reset clears prescale, source, enable fields
// - Count register reads counter; writes ignored
// - Any modulo write clears both counters
// - Reset loads modulo and counter with zero
// - Match returns counter to zero, sets flag
// - Modulo zero sets flag every prescaler tick
// - Counter advances one per prescaler tick
// - Debug halt freezes counting, resumes afterwards
// - Converter trigger pulse on every match
package rtcpw_pkg;

    // ============================================================
    // Register map (word aligned byte addresses)
    localparam logic [11:0] RTCPW_OFF_STATUS = 12'h000;
    localparam logic [11:0] RTCPW_OFF_COUNT = 12'h004;
    localparam logic [11:0] RTCPW_OFF_LIMIT = 12'h008;

    // ============================================================
    // Field layout of the status/control register
    localparam int RTCPW_FLAG_BIT = 7;
    localparam logic [7:0] RTCPW_CNT_RST = 8'h00;
    localparam logic [7:0] RTCPW_LIMIT_RST = 8'h00;
    localparam logic [1:0] RTCPW_SRC_LPO = 2'h0;
    localparam logic [1:0] RTCPW_SRC_EXT = 2'h1;
    localparam logic [3:0] RTCPW_PS_OFF = 4'h0;

    typedef struct packed {
        logic match_flag;
        logic [1:0] source_select;
        logic match_irq_enable;
        logic [3:0] prescale_select;
    } rtcpw_ctrl_t;

    localparam rtcpw_ctrl_t RTCPW_CTRL_RST = 8'h00;

    // ============================================================
    // Divide ratios, indexed by prescale_select
    localparam int RTCPW_DIV_W = 18;
    localparam logic [17:0] RTCPW_DIV_LO [16] = '{
        18'h00000, 18'h00008, 18'h00020, 18'h00040,
        18'h00080, 18'h00100, 18'h00200, 18'h00400,
        18'h00001, 18'h00002, 18'h00004, 18'h0000A,
        18'h00010, 18'h00064, 18'h001F4, 18'h003E8};
    localparam logic [17:0] RTCPW_DIV_HI [16] = '{
        18'h00000, 18'h00400, 18'h00800, 18'h01000,
        18'h02000, 18'h04000, 18'h08000, 18'h10000,
        18'h003E8, 18'h007D0, 18'h01388, 18'h02710,
        18'h04E20, 18'h0C350, 18'h186A0, 18'h30D40};

endpackage : rtcpw_pkg

/* File: rtcpw_prescaler.sv */
module rtcpw_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_edge,
    input wire logic src_bit0,
    input wire logic [3:0] prescale_select,
    input wire logic clear,
    input wire logic halt,
    output logic tick_r
);

    logic [17:0] div_cnt_r;
    logic [17:0] div_cnt_nxt;
    logic [17:0] ratio;
    logic step;

    // ============================================================
    // Ratio lookup
    function automatic logic [17:0] ratio_of(input logic sel0, input logic [3:0] ps);
        ratio_of = sel0 ? rtcpw_pkg::RTCPW_DIV_HI[ps] : rtcpw_pkg::RTCPW_DIV_LO[ps];
    endfunction : ratio_of

    // Ratio picked by source bit 0 and prescale code
    assign ratio = ratio_of(src_bit0, prescale_select);
    // Code zero means off; debug halt freezes the divider mid-count
    assign step = src_edge && !halt && (prescale_select != rtcpw_pkg::RTCPW_PS_OFF);
    assign div_cnt_nxt = (div_cnt_r >= ratio - 18'h00001) ? 18'h00000 : div_cnt_r + 18'h00001;

    // ============================================================
    // Divider count and output pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= 18'h00000;
            tick_r <= 1'b0;
        end
        else if (clear)
        begin
            div_cnt_r <= 18'h00000;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= step && (div_cnt_nxt == 18'h00000);
            if (step)
            begin
                div_cnt_r <= div_cnt_nxt;
            end
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_off_no_tick: assert property (
        (prescale_select == rtcpw_pkg::RTCPW_PS_OFF) && !clear |=> !tick_r)
        else $error("prescaler ticked while off");
    a_div1_each_edge: assert property (
        step && !clear && (ratio == 18'h00001) |=> tick_r)
        else $error("divide by one missed an edge");

endmodule : rtcpw_prescaler

/* File: rtcpw_counter.sv */
module rtcpw_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_power_osc_clock,
    input wire logic external_ref_clock,
    input wire logic internal_ref_clock,
    input wire logic debug_halt,
    output logic match_irq,
    output logic adc_trigger
);

    // ============================================================
    // Declarations
    rtcpw_pkg::rtcpw_ctrl_t ctrl_r;
    rtcpw_pkg::rtcpw_ctrl_t wr_ctrl;
    logic [7:0] count_value_r;
    logic [7:0] match_limit_r;
    logic [31:0] prdata_r;
    logic adc_trigger_r;
    logic lpo_q_r;
    logic ext_q_r;
    logic int_q_r;
    logic src_level;
    logic src_q;
    logic src_edge;
    logic tick;
    logic wr_en;
    logic rd_setup;
    logic wr_status;
    logic wr_count;
    logic wr_limit;
    logic cfg_changed;
    logic clear_cnt;
    logic match_evt;

    // ============================================================
    // Address decode
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = addr_hit(a, rtcpw_pkg::RTCPW_OFF_STATUS)
            || addr_hit(a, rtcpw_pkg::RTCPW_OFF_COUNT)
            || addr_hit(a, rtcpw_pkg::RTCPW_OFF_LIMIT);
    endfunction : addr_mapped

    // ============================================================
    // APB slave: zero wait, error on unmapped access
    // Every access finishes in one access cycle, so pready is constant
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign prdata = prdata_r;
    assign wr_en = psel && penable && pwrite && addr_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_status = wr_en && addr_hit(paddr, rtcpw_pkg::RTCPW_OFF_STATUS);
    assign wr_count = wr_en && addr_hit(paddr, rtcpw_pkg::RTCPW_OFF_COUNT);
    assign wr_limit = wr_en && addr_hit(paddr, rtcpw_pkg::RTCPW_OFF_LIMIT);
    assign wr_ctrl = pwdata[7:0];

    // Read data captured in setup so it comes from a flip-flop in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h00000000;
        end
        else if (rd_setup)
        begin
            if (addr_hit(paddr, rtcpw_pkg::RTCPW_OFF_STATUS))
            begin
                prdata_r <= {24'h000000, ctrl_r};
            end
            else if (addr_hit(paddr, rtcpw_pkg::RTCPW_OFF_COUNT))
            begin
                prdata_r <= {24'h000000, count_value_r};
            end
            else if (addr_hit(paddr, rtcpw_pkg::RTCPW_OFF_LIMIT))
            begin
                prdata_r <= {24'h000000, match_limit_r};
            end
            else
            begin
                prdata_r <= 32'h00000000;
            end
        end
    end

    // ============================================================
    // Clock source selection and edge detect
    // Sources are sampled as synchronous levels; all three are sampled
    // every pclk, so a newly chosen source gives no false edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lpo_q_r <= 1'b0;
            ext_q_r <= 1'b0;
            int_q_r <= 1'b0;
        end
        else
        begin
            lpo_q_r <= low_power_osc_clock;
            ext_q_r <= external_ref_clock;
            int_q_r <= internal_ref_clock;
        end
    end

    // Source mux: 00 low-power, 01 external, 1x internal
    always_comb
    begin
        if (ctrl_r.source_select == rtcpw_pkg::RTCPW_SRC_LPO)
        begin
            src_level = low_power_osc_clock;
            src_q = lpo_q_r;
        end
        else if (ctrl_r.source_select == rtcpw_pkg::RTCPW_SRC_EXT)
        begin
            src_level = external_ref_clock;
            src_q = ext_q_r;
        end
        else
        begin
            src_level = internal_ref_clock;
            src_q = int_q_r;
        end
    end

    assign src_edge = src_level && !src_q;

    // ============================================================
    // Counter clear conditions
    // A status write clears only on a real source or prescale change; any limit write clears
    assign cfg_changed = (wr_ctrl.source_select != ctrl_r.source_select)
        || (wr_ctrl.prescale_select != ctrl_r.prescale_select);
    assign clear_cnt = (wr_status && cfg_changed) || wr_limit;

    rtcpw_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .src_edge(src_edge),
        .src_bit0(ctrl_r.source_select[0]),
        .prescale_select(ctrl_r.prescale_select),
        .clear(clear_cnt),
        .halt(debug_halt),
        .tick_r(tick)
    );

    // Match event: a tick while the count sits at the limit
    assign match_evt = tick && !clear_cnt && !debug_halt
        && (count_value_r == match_limit_r);

    // ============================================================
    // Status/control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= rtcpw_pkg::RTCPW_CTRL_RST;
        end
        else
        begin
            if (wr_status)
            begin
                ctrl_r.source_select <= wr_ctrl.source_select;
                ctrl_r.match_irq_enable <= wr_ctrl.match_irq_enable;
                ctrl_r.prescale_select <= wr_ctrl.prescale_select;
            end
            // A match in the clearing cycle wins so no event is lost
            if (match_evt)
            begin
                ctrl_r.match_flag <= 1'b1;
            end
            else if (wr_status && pwdata[rtcpw_pkg::RTCPW_FLAG_BIT])
            begin
                ctrl_r.match_flag <= 1'b0;
            end
        end
    end

    // ============================================================
    // Limit register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_limit_r <= rtcpw_pkg::RTCPW_LIMIT_RST;
        end
        else if (wr_limit)
        begin
            match_limit_r <= pwdata[7:0];
        end
    end

    // ============================================================
    // Main 8-bit counter; writes to the count address do nothing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_value_r <= rtcpw_pkg::RTCPW_CNT_RST;
        end
        else if (clear_cnt)
        begin
            count_value_r <= rtcpw_pkg::RTCPW_CNT_RST;
        end
        else if (match_evt)
        begin
            count_value_r <= rtcpw_pkg::RTCPW_CNT_RST;
        end
        else if (tick && !debug_halt)
        begin
            count_value_r <= count_value_r + 8'h01;
        end
    end

    // ============================================================
    // Converter trigger, independent of the interrupt enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_trigger_r <= 1'b0;
        end
        else
        begin
            adc_trigger_r <= match_evt;
        end
    end

    assign adc_trigger = adc_trigger_r;
    // Level request straight from two register bits
    assign match_irq = ctrl_r.match_flag && ctrl_r.match_irq_enable;

    // ============================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_match;
        tick && !clear_cnt && !debug_halt && (count_value_r == match_limit_r);
    endsequence

    sequence s_flag_clear_write;
        wr_status && pwdata[rtcpw_pkg::RTCPW_FLAG_BIT] && !match_evt;
    endsequence

    a_match_sets_flag: assert property (s_match |=> ctrl_r.match_flag)
        else $error("match did not set the flag");
    a_match_wraps_zero: assert property (
        s_match |=> (count_value_r == 8'h00))
        else $error("counter did not wrap on match");
    a_flag_w1c: assert property (s_flag_clear_write |=> !ctrl_r.match_flag)
        else $error("write one did not clear flag");
    a_flag_w0_keep: assert property (
        ctrl_r.match_flag && wr_status && !pwdata[rtcpw_pkg::RTCPW_FLAG_BIT]
        |=> ctrl_r.match_flag)
        else $error("write zero changed the flag");
    a_irq_follows_flag: assert property (
        s_flag_clear_write ##1 ctrl_r.match_irq_enable |-> !match_irq)
        else $error("interrupt stayed after flag clear");
    a_limit_write_clr: assert property (
        wr_limit |=> (count_value_r == 8'h00) && !tick)
        else $error("limit write did not clear counters");
    a_cfg_change_clr: assert property (
        wr_status && cfg_changed |=> (count_value_r == 8'h00))
        else $error("config change did not clear counter");
    a_count_ro: assert property (
        wr_count && !tick |=> $stable(count_value_r))
        else $error("count register took a write");
    a_halt_freezes: assert property (
        debug_halt && !clear_cnt |=> $stable(count_value_r))
        else $error("counter moved in debug halt");
    a_trig_on_match: assert property (
        s_match ##1 !match_evt |-> adc_trigger ##1 !adc_trigger)
        else $error("trigger pulse missing on match");
    a_advance_one: assert property (
        tick && !clear_cnt && !debug_halt && (count_value_r != match_limit_r)
        |=> count_value_r == $past(count_value_r) + 8'h01)
        else $error("counter did not advance by one");

endmodule : rtcpw_counter

/* File: tb_periodic_wakeup_counter.sv */
module tb_periodic_wakeup_counter;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, debug_halt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, match_irq, adc_trigger;
    logic [2:0] src;
    logic [32:0] exp_q[$];
    logic [7:0] lim;
    int fail_count, tests_run, adc_n, s;
    // Ratio table: source field, prescale code, expected divide ratio
    localparam int TS [19] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 1, 3, 2};
    localparam int TC [19] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 9, 1, 8, 8};
    localparam int TR [19] = '{8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000,
        2, 1024, 1000, 1};

    rtcpw_counter uut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .low_power_osc_clock(src[0]),
        .external_ref_clock(src[1]),
        .internal_ref_clock(src[2]),
        .debug_halt(debug_halt),
        .match_irq(match_irq),
        .adc_trigger(adc_trigger)
    );

    // ============================================================
    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ============================================================
    // Checking and verdict
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // Read results pop the oldest note; an empty queue is itself a miss
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            if (exp_q.size() == 0)
                chk({pslverr, prdata}, 33'h1FFFFFFFF);
            else
                chk({pslverr, prdata}, exp_q.pop_front());
        end
        if (adc_trigger === 1'b1)
            adc_n++;
    end

    // ============================================================
    // APB master and source edge drivers
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Hold the request until pready is seen high; only the watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        apb(a, 1'b1, {8'($urandom_range(255, 0)), 16'h0000, v});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] v);
        exp_q.push_back({25'h0000000, v});
        apb(a, 1'b0, 32'h00000000);
    endtask : rd

    task automatic irq(input logic e);
        @(negedge pclk);
        chk({32'h0, match_irq}, {32'h0, e});
    endtask : irq

    // One-cycle-high pulses keep each level for at least a full pclk
    task automatic pulse(input int k, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            src[k] <= 1'b1;
            @(posedge pclk);
            src[k] <= 1'b0;
        end
        repeat (3) @(posedge pclk);
    endtask : pulse

    // ============================================================
    // Watchdog sized well beyond the roughly 23k cycles of traffic
    initial
    begin
        repeat (80000) @(posedge pclk);
        fail_count++;
        final_report();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, debug_halt} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        src = 3'h0;
        void'($urandom(32'h2B6F0155));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h00);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h00);
        rd(rtcpw_pkg::RTCPW_OFF_LIMIT, 8'h00);
        exp_q.push_back({1'b1, 32'h00000000});
        apb(12'h00C, 1'b0, 32'h00000000);
        pulse(0, 3);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h00);
        lim = 8'($urandom_range(40, 3));
        wr(rtcpw_pkg::RTCPW_OFF_LIMIT, lim);
        wr(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h08);
        pulse(0, lim);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, lim);
        rd(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h08);
        pulse(0, 1);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h00);
        rd(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h88);
        chk(33'(adc_n), 33'h1);
        irq(1'b0);
        wr(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h18);
        irq(1'b1);
        rd(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h98);
        wr(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h55);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h00);
        wr(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h98);
        irq(1'b0);
        rd(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h18);
        pulse(0, 2);
        wr(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h18);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h02);
        wr(rtcpw_pkg::RTCPW_OFF_LIMIT, lim);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h00);
        pulse(0, 2);
        debug_halt <= 1'b1;
        pulse(0, 3);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h02);
        debug_halt <= 1'b0;
        pulse(0, 1);
        pulse(1, 4);
        pulse(2, 4);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h03);
        wr(rtcpw_pkg::RTCPW_OFF_LIMIT, 8'h00);
        adc_n = 0;
        pulse(0, 3);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h00);
        chk(33'(adc_n), 33'h3);
        irq(1'b1);
        wr(rtcpw_pkg::RTCPW_OFF_LIMIT, 8'hFF);
        // Exactly R edges give one tick, R - 1 more give none: catches both too fast and too slow
        for (int i = 0; i < 19; i++)
        begin
            s = (TS[i] > 1) ? 2 : TS[i];
            wr(rtcpw_pkg::RTCPW_OFF_STATUS, {1'b1, 2'(TS[i]), 1'b0, 4'(TC[i])});
            pulse(s, TR[i]);
            rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h01);
            pulse(s, TR[i] - 1);
            rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h01);
        end
        wr(rtcpw_pkg::RTCPW_OFF_STATUS, 8'h80);
        pulse(0, 5);
        rd(rtcpw_pkg::RTCPW_OFF_COUNT, 8'h00);
        repeat (4) @(posedge pclk);
        chk(33'(exp_q.size()), 33'h0);
        final_report();
    end
endmodule : tb_periodic_wakeup_counter
